// file: hw/fcl_exec.sv
// Execution slice: fused compare-branch, bit ops, sign extend, cache block ops, loads, mark.
// Assumes one clock shared with the APB master, the load port and the data cache port.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "fcl_defs.svh"

// Contract
// - Logical fused compare sets condition field zero from an unsigned compare.
// - Selector three subtracts into first source and branches on equality match.
// - Other selectors keep first source; selected bit must equal polarity to branch.
// - Signed fused compare behaves the same but compares signed.
// - Immediate fused compare uses the instruction immediate as second operand.
// - Count leading zeros into target; dot form updates condition field zero.
// - Condition register logical operations are not provided.
// - Flush writes back then invalidates the block; invalidate only invalidates.
// - Query interrogates the block at base-or-zero plus index.
// - Touch fetches the block at base-or-zero plus index into the cache.
// - Zero clears the whole block at base-or-zero plus index.
// - Equivalence writes complement of exclusive-or; dot form updates field zero.
// - Byte and halfword sign extension fill the target; dot forms update field zero.
// - Byte loads zero-fill upper bits, displacement or indexed addressing.
// - Halfword loads zero-fill upper sixteen bits, both addressing forms.
// - Word loads place four bytes unchanged into the target.
// - Update forms write the effective address back into the base register.
// - Doubleword loads fill a register pair, displacement, update and indexed.
// - Full context restore loads exception word, ten doublewords, link word, base.
// - Partial restore acts full on displacement bit two, else zero to two doublewords.
// - Mark with low instruction bit clear emits both register fields to trace.
// - Invalid mark operand raises program interrupt and records cause.
module fcl_exec #(
   parameter bit HAS_64 = 1'b1,
   parameter logic [31:0] GPR_VALID = 32'hFFFFFFFF
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output fcl_pkg::fcl_mem_s mem_o,
   input wire logic mem_ack,
   input wire logic [63:0] mem_rdata,
   output fcl_pkg::fcl_dc_s dc_o,
   input wire logic dc_ack,
   input wire logic dc_hit,
   output logic trace_valid,
   output logic [9:0] trace_data,
   output logic prog_int
);

   fcl_pkg::fcl_state_s s_q;
   fcl_pkg::fcl_state_s s_d;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lead_zeros(input logic [31:0] v);
      logic hit;
      lead_zeros = 32'h0;
      hit = 1'b0;
      for (int k = 31; k >= 0; k--) begin
         hit = hit | v[k];
         if (!hit) begin
            lead_zeros = lead_zeros + 32'h1;
         end
      end
   endfunction

   function automatic logic [3:0] cr_of(input logic [31:0] r, input logic so);
      cr_of = {r[31], ~r[31] & (|r), ~(|r), so};
   endfunction

   // Destination of restore doubleword k: bit 5 picks the special bank, else a GPR pair.
   function automatic logic [5:0] ctx_dst(input logic [3:0] k);
      case (k)
         4'h0: ctx_dst = 6'h1E;
         4'h1: ctx_dst = 6'h1C;
         4'h2: ctx_dst = 6'h20;
         4'h3: ctx_dst = 6'h22;
         4'h4: ctx_dst = 6'h09;
         4'h5: ctx_dst = 6'h07;
         4'h6: ctx_dst = 6'h05;
         4'h7: ctx_dst = 6'h03;
         4'h8: ctx_dst = 6'h00;
         default: ctx_dst = 6'h24;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] i, rs_v, ra_v, rb_v, base, ea_d, ea_x, cb, res, rd, isr_set;
      logic [3:0] cr;
      logic [3:0] sn;
      logic [5:0] dst;
      logic [4:0] rt;
      logic [4:0] rt1;
      logic acc, done, wr, busy, issue, lt, eq, tk, so;
      i = pwdata;
      rs_v = s_q.gpr[pwdata[25:21]];
      ra_v = s_q.gpr[pwdata[20:16]];
      rb_v = s_q.gpr[pwdata[15:11]];
      base = (pwdata[20:16] == 5'h0) ? 32'h0 : ra_v;
      ea_d = base + {{16{pwdata[15]}}, pwdata[15:0]};
      ea_x = base + rb_v;
      cb = rb_v;
      res = 32'h0;
      rd = 32'h0;
      isr_set = 32'h0;
      cr = 4'h0;
      sn = s_q.step + 4'h1;
      dst = 6'h0;
      rt = s_q.ins[25:21];
      rt1 = s_q.ins[25:21] + 5'h1;
      acc = psel & penable & ~s_q.pready;
      done = psel & penable & s_q.pready;
      wr = done & pwrite & ~s_q.pslverr;
      busy = s_q.st != fcl_pkg::FCL_IDLE;
      issue = 1'b0;
      lt = 1'b0;
      eq = 1'b0;
      tk = 1'b0;
      so = s_q.spr[`FCL_SPR_XER][31];
      s_d = s_q;
      s_d.trace_v = 1'b0;
      s_d.prog_int = 1'b0;

      // ----------------------------------------------------------------
      // APB slave: answer registered in the first access cycle
      // ----------------------------------------------------------------
      s_d.pready = acc;
      s_d.pslverr = 1'b0;
      if (acc) begin
         s_d.pslverr = pwrite & busy;
         case (paddr)
            `FCL_A_INSTR: rd = s_q.ins;
            `FCL_A_CIA: rd = s_q.cia;
            `FCL_A_STAT: begin
               rd = {25'h0, s_q.qhit, s_q.taken, busy, s_q.cr0};
               s_d.pslverr = pwrite;
            end
            `FCL_A_LR: rd = s_q.lr;
            `FCL_A_EDR: rd = s_q.exception_data_register;
            `FCL_A_ISR: rd = s_q.interrupt_status_register;
            `FCL_A_GSEL: rd = {27'h0, s_q.gsel};
            `FCL_A_GDAT: rd = s_q.gpr[s_q.gsel];
            default: begin
               if (paddr >= `FCL_A_SPR0 && paddr < `FCL_A_SPR_END && paddr[1:0] == 2'h0) begin
                  rd = s_q.spr[paddr[4:2]];
                  s_d.pslverr = pwrite;
               end else begin
                  s_d.pslverr = 1'b1;
               end
            end
         endcase
         s_d.prdata = rd;
      end
      if (wr) begin
         case (paddr)
            `FCL_A_INSTR: issue = 1'b1;
            `FCL_A_CIA: s_d.cia = pwdata;
            `FCL_A_LR: s_d.lr = pwdata;
            `FCL_A_EDR: s_d.exception_data_register = pwdata;
            `FCL_A_ISR: s_d.interrupt_status_register = s_q.interrupt_status_register & ~pwdata;
            `FCL_A_GSEL: s_d.gsel = pwdata[4:0];
            `FCL_A_GDAT: s_d.gpr[s_q.gsel] = pwdata;
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // Issue: single-cycle ops finish here, memory and cache ops start
      // ----------------------------------------------------------------
      if (issue) begin
         s_d.ins = i;
         s_d.cia = s_q.cia + 32'h4;
         s_d.taken = 1'b0;
         s_d.ctx = 1'b0;
         s_d.step = 4'h0;
         s_d.upd = 1'b0;
         s_d.ea = ea_d;
         case (i[31:26])
            `FCL_OP_CMPLWBC, `FCL_OP_CMPWBC, `FCL_OP_CMPWIBC: begin
               if (i[31:26] == `FCL_OP_CMPWIBC) begin
                  cb = {27'h0, i[15:11]};
               end
               if (i[31:26] == `FCL_OP_CMPLWBC) begin
                  lt = ra_v < cb;
               end else begin
                  lt = $signed(ra_v) < $signed(cb);
               end
               eq = ra_v == cb;
               cr = {lt, ~lt & ~eq, eq, so};
               s_d.cr0 = cr;
               if (i[24:23] == 2'h3) begin
                  s_d.gpr[i[20:16]] = ra_v - cb;
                  tk = i[25] == eq;
               end else begin
                  tk = i[25] == cr[2'h3 - i[24:23]];
               end
               if (tk) begin
                  s_d.cia = s_q.cia + {{20{i[10]}}, i[10:1], 2'b00};
               end
               s_d.taken = tk;
               if (i[0]) begin
                  s_d.lr = s_q.cia + 32'h4;
               end
            end
            `FCL_OP_CNTLZW, `FCL_OP_EQV, `FCL_OP_EXTSB, `FCL_OP_EXTSH: begin
               case (i[31:26])
                  `FCL_OP_CNTLZW: res = lead_zeros(rs_v);
                  `FCL_OP_EQV: res = ~(rs_v ^ rb_v);
                  `FCL_OP_EXTSB: res = {{24{rs_v[7]}}, rs_v[7:0]};
                  default: res = {{16{rs_v[15]}}, rs_v[15:0]};
               endcase
               s_d.gpr[i[20:16]] = res;
               if (i[0]) begin
                  s_d.cr0 = cr_of(res, so);
               end
            end
            `FCL_OP_DCBF, `FCL_OP_DCBI, `FCL_OP_DCBQ, `FCL_OP_DCBT, `FCL_OP_DCBZ: begin
               s_d.st = fcl_pkg::FCL_CACHE;
               s_d.dc.req = 1'b1;
               s_d.dc.addr = ea_x;
               s_d.dc.op = i[28:26] - 3'h1;
            end
            `FCL_OP_LBZ, `FCL_OP_LBZU, `FCL_OP_LBZX, `FCL_OP_LHZ, `FCL_OP_LHZU,
            `FCL_OP_LHZX, `FCL_OP_LWZ, `FCL_OP_LWZU, `FCL_OP_LWZX, `FCL_OP_LVD,
            `FCL_OP_LVDU, `FCL_OP_LVDX: begin
               if (i[31:26] == `FCL_OP_LBZX || i[31:26] == `FCL_OP_LHZX ||
                   i[31:26] == `FCL_OP_LWZX || i[31:26] == `FCL_OP_LVDX) begin
                  s_d.ea = ea_x;
               end
               s_d.upd = i[31:26] == `FCL_OP_LBZU || i[31:26] == `FCL_OP_LHZU ||
                         i[31:26] == `FCL_OP_LWZU || i[31:26] == `FCL_OP_LVDU;
               s_d.st = fcl_pkg::FCL_MEM;
               s_d.mem.req = 1'b1;
               s_d.mem.addr = s_d.ea;
               s_d.mem.size = 2'((i[31:26] - `FCL_OP_LBZ) / 6'h3);
            end
            `FCL_OP_LCXU, `FCL_OP_LSKU: begin
               if (HAS_64) begin
                  s_d.ea = ra_v + {{16{i[15]}}, i[15:0]};
                  s_d.ctx = 1'b1;
                  s_d.st = fcl_pkg::FCL_MEM;
                  s_d.mem.req = 1'b1;
                  s_d.mem.addr = s_d.ea;
                  s_d.mem.size = `FCL_SZ_W;
                  if (i[31:26] == `FCL_OP_LCXU || i[2]) begin
                     s_d.nld = `FCL_CTX_FULL;
                  end else if (i[4:3] == 2'h3) begin
                     s_d.nld = `FCL_CTX_PART_MAX;
                  end else begin
                     s_d.nld = {2'h0, i[4:3]};
                  end
               end else begin
                  isr_set = `FCL_ISR_ILLEGAL;
               end
            end
            `FCL_OP_MARK: begin
               if (i[0]) begin
                  isr_set = `FCL_ISR_ILLEGAL;
               end else if (!GPR_VALID[i[20:16]] || !GPR_VALID[i[15:11]]) begin
                  isr_set = `FCL_ISR_MARK_BAD;
               end else begin
                  s_d.trace_v = 1'b1;
                  s_d.trace_d = {i[20:16], i[15:11]};
               end
            end
            default: isr_set = `FCL_ISR_ILLEGAL;
         endcase
         if (isr_set != 32'h0) begin
            s_d.prog_int = 1'b1;
            s_d.exception_data_register = i;
         end
      end

      // ----------------------------------------------------------------
      // Memory and cache completion
      // ----------------------------------------------------------------
      case (s_q.st)
         fcl_pkg::FCL_IDLE: ;
         fcl_pkg::FCL_CACHE: begin
            if (dc_ack) begin
               s_d.dc.req = 1'b0;
               s_d.st = fcl_pkg::FCL_IDLE;
               if (s_q.dc.op == `FCL_DC_QUERY) begin
                  s_d.qhit = dc_hit;
               end
            end
         end
         fcl_pkg::FCL_MEM: begin
            if (mem_ack && !s_q.ctx) begin
               case (s_q.mem.size)
                  `FCL_SZ_B: s_d.gpr[rt] = {24'h0, mem_rdata[7:0]};
                  `FCL_SZ_H: s_d.gpr[rt] = {16'h0, mem_rdata[15:0]};
                  `FCL_SZ_W: s_d.gpr[rt] = mem_rdata[31:0];
                  default: begin
                     s_d.gpr[rt] = mem_rdata[63:32];
                     s_d.gpr[rt1] = mem_rdata[31:0];
                  end
               endcase
               if (s_q.upd) begin
                  s_d.gpr[s_q.ins[20:16]] = s_q.ea;
               end
               s_d.mem.req = 1'b0;
               s_d.st = fcl_pkg::FCL_IDLE;
            end else if (mem_ack) begin
               s_d.step = sn;
               s_d.mem.size = `FCL_SZ_D;
               s_d.mem.addr = s_q.ea - {25'h0, sn, 3'h0};
               if (s_q.step == 4'h0) begin
                  s_d.exception_data_register = mem_rdata[31:0];
               end else if (s_q.step <= s_q.nld) begin
                  dst = ctx_dst(s_q.step - 4'h1);
                  if (dst[5]) begin
                     s_d.spr[dst[2:0]] = mem_rdata[63:32];
                     s_d.spr[dst[2:0] + 3'h1] = mem_rdata[31:0];
                     if (dst[2:0] == `FCL_SPR_CR) begin
                        s_d.cr0 = mem_rdata[63:60];
                     end
                  end else begin
                     s_d.gpr[dst[4:0]] = mem_rdata[63:32];
                     s_d.gpr[dst[4:0] + 5'h1] = mem_rdata[31:0];
                  end
               end else begin
                  s_d.lr = mem_rdata[31:0];
                  s_d.gpr[s_q.ins[20:16]] = s_q.ea;
                  s_d.mem.req = 1'b0;
                  s_d.st = fcl_pkg::FCL_IDLE;
               end
               if (sn > s_q.nld) begin
                  s_d.mem.size = `FCL_SZ_W;
                  s_d.mem.addr = s_q.ea + 32'h4;
               end
            end
         end
         default: s_d.st = fcl_pkg::FCL_IDLE;
      endcase

      // A cause arriving with a software clear is kept.
      s_d.interrupt_status_register = s_d.interrupt_status_register | isr_set;
   end

   // ----------------------------------------------------------------
   // State register and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign mem_o = s_q.mem;
   assign dc_o = s_q.dc;
   assign trace_valid = s_q.trace_v;
   assign trace_data = s_q.trace_d;
   assign prog_int = s_q.prog_int;

endmodule

// file: include/fcl_defs.svh
// Constants of the fused compare, bit, cache and load execution slice.
// Assumes inclusion by bare name from the design and the test bench.
`ifndef FCL_DEFS_SVH
`define FCL_DEFS_SVH

// ----------------------------------------------------------------
// Opcode field, instruction bits 31:26
// ----------------------------------------------------------------
`define FCL_OP_CMPLWBC 6'h01
`define FCL_OP_CMPWBC 6'h02
`define FCL_OP_CMPWIBC 6'h03
`define FCL_OP_CNTLZW 6'h04
`define FCL_OP_EQV 6'h05
`define FCL_OP_EXTSB 6'h06
`define FCL_OP_EXTSH 6'h07
`define FCL_OP_CRLOGIC 6'h08
`define FCL_OP_DCBF 6'h09
`define FCL_OP_DCBI 6'h0A
`define FCL_OP_DCBQ 6'h0B
`define FCL_OP_DCBT 6'h0C
`define FCL_OP_DCBZ 6'h0D
`define FCL_OP_LBZ 6'h10
`define FCL_OP_LBZU 6'h11
`define FCL_OP_LBZX 6'h12
`define FCL_OP_LHZ 6'h13
`define FCL_OP_LHZU 6'h14
`define FCL_OP_LHZX 6'h15
`define FCL_OP_LWZ 6'h16
`define FCL_OP_LWZU 6'h17
`define FCL_OP_LWZX 6'h18
`define FCL_OP_LVD 6'h19
`define FCL_OP_LVDU 6'h1A
`define FCL_OP_LVDX 6'h1B
`define FCL_OP_LCXU 6'h1C
`define FCL_OP_LSKU 6'h1D
`define FCL_OP_MARK 6'h20

// ----------------------------------------------------------------
// Load sizes, cache operations, special register slots, restore counts
// ----------------------------------------------------------------
`define FCL_SZ_B 2'h0
`define FCL_SZ_H 2'h1
`define FCL_SZ_W 2'h2
`define FCL_SZ_D 2'h3
`define FCL_DC_FLUSH 3'h0
`define FCL_DC_INVAL 3'h1
`define FCL_DC_QUERY 3'h2
`define FCL_DC_TOUCH 3'h3
`define FCL_DC_ZERO 3'h4
`define FCL_SPR_XER 3'h2
`define FCL_SPR_CR 3'h4
`define FCL_CTX_FULL 4'hA
`define FCL_CTX_PART_MAX 4'h2

// ----------------------------------------------------------------
// APB byte offsets and status bits
// ----------------------------------------------------------------
`define FCL_A_INSTR 8'h00
`define FCL_A_CIA 8'h04
`define FCL_A_STAT 8'h08
`define FCL_A_LR 8'h0C
`define FCL_A_EDR 8'h10
`define FCL_A_ISR 8'h14
`define FCL_A_GSEL 8'h18
`define FCL_A_GDAT 8'h1C
`define FCL_A_SPR0 8'h20
`define FCL_A_SPR_END 8'h38
`define FCL_ISR_ILLEGAL 32'h00000001
`define FCL_ISR_MARK_BAD 32'h00000002

`endif

// file: include/fcl_pkg.sv
// Types of the fused compare, bit, cache and load execution slice.
// Assumes nothing of its surroundings.
package fcl_pkg;

   typedef enum logic [1:0] {FCL_IDLE, FCL_MEM, FCL_CACHE} fcl_st_e;

   typedef struct packed {
      logic req;
      logic [31:0] addr;
      logic [1:0] size;
   } fcl_mem_s;

   typedef struct packed {
      logic req;
      logic [2:0] op;
      logic [31:0] addr;
   } fcl_dc_s;

   typedef struct packed {
      fcl_st_e st;
      logic [31:0] cia;
      logic [31:0] lr;
      logic [31:0] exception_data_register;
      logic [31:0] interrupt_status_register;
      logic [31:0] ins;
      logic [31:0] ea;
      logic [3:0] cr0;
      logic [3:0] step;
      logic [3:0] nld;
      logic ctx;
      logic upd;
      logic taken;
      logic qhit;
      logic [4:0] gsel;
      logic [31:0][31:0] gpr;
      logic [5:0][31:0] spr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      fcl_mem_s mem;
      fcl_dc_s dc;
      logic trace_v;
      logic [9:0] trace_d;
      logic prog_int;
   } fcl_state_s;

endpackage

// file: verif/fcl_exec_monitor.sv
// Port checker of the execution slice.
// Bound to fcl_exec; sees only that module's ports.
`timescale 1ns/100ps
module fcl_exec_monitor (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire fcl_pkg::fcl_mem_s mem_o,
   input wire logic mem_ack,
   input wire fcl_pkg::fcl_dc_s dc_o,
   input wire logic dc_ack,
   input wire logic trace_valid,
   input wire logic [9:0] trace_data,
   input wire logic prog_int
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic issue;
   logic [5:0] opc;
   logic [5:0] dop;
   logic [1:0] lsz;
   assign opc = pwdata[31:26];
   assign dop = opc - 6'h09;
   // An accepted instruction write is the only launch point of an operation.
   assign issue = psel && penable && pready && !pslverr && pwrite && paddr == 8'h00;
   assign lsz = (opc < 6'h13) ? 2'h0 : (opc < 6'h16) ? 2'h1 : (opc < 6'h19) ? 2'h2 : 2'h3;
   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("late answer");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   load_size_a: assert property (issue && opc inside {[6'h10:6'h1B]}
      |=> mem_o.req && mem_o.size == $past(lsz)) else $error("load request wrong");
   mem_hold_a: assert property (mem_o.req && !mem_ack
      |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.size))
      else $error("load request moved");
   cache_op_a: assert property (issue && opc inside {[6'h09:6'h0D]}
      |=> dc_o.req && dc_o.op == $past(dop[2:0])) else $error("cache request wrong");
   dc_hold_a: assert property (dc_o.req && !dc_ack
      |=> dc_o.req && $stable(dc_o.addr) && $stable(dc_o.op))
      else $error("cache request moved");
   mark_trace_a: assert property (issue && opc == 6'h20 && !pwdata[0] |=> prog_int ||
      trace_valid && trace_data == $past(pwdata[20:11]))
      else $error("mark not traced");
   cr_logic_a: assert property (issue && opc == 6'h08 |=> prog_int && !trace_valid)
      else $error("logic op accepted");
   start_quiet_a: assert property ($fell(sys_rst) |-> !mem_o.req && !dc_o.req && !prog_int)
      else $error("active after reset");
   cover property (trace_valid);
   cover property (dc_o.req && dc_ack);
   cover property (mem_o.req && mem_ack);
   cover property (prog_int);
endmodule
bind fcl_exec fcl_exec_monitor i_fcl_exec_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .mem_o(mem_o), .mem_ack(mem_ack), .dc_o(dc_o),
   .dc_ack(dc_ack), .trace_valid(trace_valid), .trace_data(trace_data), .prog_int(prog_int));

// file: verif/fcl_mem_model.sv
// Memory and data cache stand-in for the load and cache block ports.
// Assumes the core clock; each request is answered after lat idle cycles.
`timescale 1ns/100ps
module fcl_mem_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] lat,
   input wire fcl_pkg::fcl_mem_s mem_o,
   output logic mem_ack,
   output logic [63:0] mem_rdata,
   input wire fcl_pkg::fcl_dc_s dc_o,
   output logic dc_ack,
   output logic dc_hit
);
   logic [3:0] mcnt;
   logic [3:0] dcnt;
   logic [31:0] a;
   assign a = mem_o.addr;
   function automatic logic [31:0] wd(input logic [31:0] x);
      return x ^ 32'hC3C33C3C;
   endfunction
   // Outside an answer the read data toggles, and dc_hit too except while a cache request waits, so stale data never looks valid.
   always_ff @(posedge core_clk) begin
      mem_ack <= 1'b0;
      dc_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      dc_hit <= ~dc_hit;
      if (sys_rst) begin
         mcnt <= 4'h0;
         dcnt <= 4'h0;
         mem_rdata <= 64'h0;
         dc_hit <= 1'b0;
      end else begin
         if (mem_o.req && !mem_ack) begin
            mcnt <= (mcnt == lat) ? 4'h0 : mcnt + 4'h1;
            if (mcnt == lat) begin
               mem_ack <= 1'b1;
               mem_rdata <= (mem_o.size == 2'h3) ? {wd(a), wd(a + 32'h4)} : {~wd(a), wd(a)};
            end
         end
         if (dc_o.req && !dc_ack) begin
            dcnt <= (dcnt == lat) ? 4'h0 : dcnt + 4'h1;
            dc_ack <= (dcnt == lat);
            dc_hit <= dc_o.addr[5];
         end
      end
   end
endmodule

// file: verif/fused_compare_load_exec_test.sv
// Self-checking bench of the execution slice, driven over APB.
// Assumes the design, its package, defines and the memory stand-in.
`timescale 1ns/100ps
`include "fcl_defs.svh"
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", nm, (e), (a)); end end
module fused_compare_load_exec_test;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, mem_ack, dc_ack, dc_hit, trace_valid, prog_int;
   logic [63:0] mem_rdata;
   logic [9:0] trace_data, tr_seen = 10'h0;
   logic [3:0] lat = 4'h0;
   fcl_pkg::fcl_mem_s mem_o;
   fcl_pkg::fcl_dc_s dc_o, dc_seen = '0;
   int bad_count = 0, num_checks = 0, pint_n = 0;
   // Register 31 is invalid so that a mark can name a bad operand.
   fcl_exec #(.HAS_64(1'b1), .GPR_VALID(32'h7FFFFFFF)) i_fcl_exec (.core_clk(core_clk),
      .sys_rst(sys_rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dc_o(dc_o), .dc_ack(dc_ack),
      .dc_hit(dc_hit), .trace_valid(trace_valid), .trace_data(trace_data), .prog_int(prog_int));
   fcl_mem_model i_fcl_mem_model (.core_clk(core_clk), .sys_rst(sys_rst), .lat(lat),
      .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dc_o(dc_o), .dc_ack(dc_ack),
      .dc_hit(dc_hit));
   initial forever #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (trace_valid) tr_seen <= trace_data;
      if (prog_int) pint_n <= pint_n + 1;
      if (dc_o.req) dc_seen <= dc_o;
   end
   function automatic logic [31:0] wd(input logic [31:0] x);
      return x ^ 32'hC3C33C3C;
   endfunction
   function automatic logic [31:0] mk(input logic [5:0] o, input logic [4:0] t,
      input logic [4:0] a, input logic [15:0] d);
      return {o, t, a, d};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setg(input logic [4:0] r, input logic [31:0] v);
      apb(1'b1, `FCL_A_GSEL, {27'h0, r});
      apb(1'b1, `FCL_A_GDAT, v);
   endtask
   task automatic getg(input logic [4:0] r);
      apb(1'b1, `FCL_A_GSEL, {27'h0, r});
      apb(1'b0, `FCL_A_GDAT, 32'h0);
   endtask
   task automatic run(input logic [31:0] ins);
      apb(1'b1, `FCL_A_INSTR, ins);
      do apb(1'b0, `FCL_A_STAT, 32'h0); while (rd[4] !== 1'b0);
   endtask
   task automatic fz(input logic [31:0] ins, input logic [31:0] cia, input logic [5:0] st);
      run(ins);
      `CHK("status", st, rd[5:0])
      apb(1'b0, `FCL_A_CIA, 32'h0);
      `CHK("next address", cia, rd)
   endtask
   task automatic t_fused();
      setg(5'h2, 32'h5);
      setg(5'h3, 32'h5);
      setg(5'h4, 32'hFFFFFFFF);
      setg(5'h5, 32'h1);
      apb(1'b1, `FCL_A_CIA, 32'h100);
      fz({`FCL_OP_CMPLWBC, 1'b1, 2'h3, 2'h0, 5'h2, 5'h3, 10'h4, 1'b1}, 32'h110, 6'h22);
      apb(1'b0, `FCL_A_LR, 32'h0);
      `CHK("link", 32'h104, rd)
      getg(5'h2);
      `CHK("difference", 32'h0, rd)
      fz({`FCL_OP_CMPLWBC, 1'b1, 2'h0, 2'h0, 5'h4, 5'h5, 10'h4, 1'b0}, 32'h114, 6'h04);
      fz({`FCL_OP_CMPWBC, 1'b1, 2'h0, 2'h0, 5'h4, 5'h5, 10'h4, 1'b0}, 32'h124, 6'h28);
      fz({`FCL_OP_CMPWIBC, 1'b0, 2'h1, 2'h0, 5'h4, 5'h3, 10'h3FF, 1'b0}, 32'h120, 6'h28);
      getg(5'h4);
      `CHK("kept operand", 32'hFFFFFFFF, rd)
   endtask
   task automatic t_loads();
      lat <= 4'h5;
      setg(5'h1, 32'h1000);
      setg(5'h2, 32'h42);
      run(mk(`FCL_OP_LBZ, 5'h3, 5'h1, 16'h0005));
      getg(5'h3);
      `CHK("byte", wd(32'h1005) & 32'hFF, rd)
      run(mk(`FCL_OP_LHZU, 5'h4, 5'h1, 16'hFFFE));
      getg(5'h4);
      `CHK("half", wd(32'hFFE) & 32'hFFFF, rd)
      getg(5'h1);
      `CHK("updated base", 32'hFFE, rd)
      run(mk(`FCL_OP_LWZX, 5'h5, 5'h1, 16'h1000));
      getg(5'h5);
      `CHK("word", wd(32'h1040), rd)
      run(mk(`FCL_OP_LVD, 5'h6, 5'h0, 16'h0010));
      getg(5'h6);
      `CHK("pair first", wd(32'h10), rd)
      getg(5'h7);
      `CHK("pair second", wd(32'h14), rd)
      run(mk(`FCL_OP_LSKU, 5'h0, 5'h2, 16'h0008));
      apb(1'b0, `FCL_A_LR, 32'h0);
      `CHK("restore link", wd(32'h4E), rd)
      lat <= 4'h0;
   endtask
   task automatic t_alu();
      setg(5'h8, 32'hF0);
      setg(5'h9, 32'h0F0F0000);
      run(mk(`FCL_OP_EQV, 5'h8, 5'hA, 16'h4800));
      getg(5'hA);
      `CHK("equivalence", 32'hF0F0FF0F, rd)
      run(mk(`FCL_OP_EXTSB, 5'h8, 5'hB, 16'h0001));
      `CHK("sign field", 4'h8, rd[3:0])
      getg(5'hB);
      `CHK("sign extend", 32'hFFFFFFF0, rd)
      run(mk(`FCL_OP_CNTLZW, 5'h9, 5'hC, 16'h0001));
      `CHK("count field", 4'h4, rd[3:0])
      getg(5'hC);
      `CHK("leading zeros", 32'h4, rd)
   endtask
   task automatic t_cache();
      setg(5'hD, 32'h3000);
      setg(5'hE, 32'h24);
      for (logic [2:0] k = 3'h0; k < 3'h5; k++) begin
         run(mk(`FCL_OP_DCBF + {3'h0, k}, 5'h0, 5'hD, 16'h7000));
         if (k == 3'h2) `CHK("query hit", 1'b1, rd[6])
         `CHK("cache op", k, dc_seen.op)
         `CHK("cache address", 32'h3024, dc_seen.addr)
      end
   endtask
   task automatic t_mark();
      int n;
      run(mk(`FCL_OP_MARK, 5'h0, 5'h3, 16'h4800));
      `CHK("trace", {5'h3, 5'h9}, tr_seen)
      n = pint_n;
      run(mk(`FCL_OP_MARK, 5'h0, 5'h1F, 16'h4800));
      `CHK("interrupts", n + 1, pint_n)
      apb(1'b0, `FCL_A_ISR, 32'h0);
      `CHK("cause", `FCL_ISR_MARK_BAD, rd)
      apb(1'b0, `FCL_A_EDR, 32'h0);
      `CHK("fault word", mk(`FCL_OP_MARK, 5'h0, 5'h1F, 16'h4800), rd)
      apb(1'b1, `FCL_A_ISR, `FCL_ISR_MARK_BAD);
      run(mk(`FCL_OP_CRLOGIC, 5'h1, 5'h2, 16'h1800));
      apb(1'b0, `FCL_A_ISR, 32'h0);
      `CHK("illegal", `FCL_ISR_ILLEGAL, rd)
   endtask
   task automatic results();
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_fused();
      t_loads();
      t_alu();
      t_cache();
      t_mark();
      results();
   end
endmodule
